// >>> inc/vbfc_pkg.sv
// Purpose: shared constants and types for the video bridge format/clock block
// Assumes: Avalon-MM slave with 32-bit data, byte addresses
// Notes: configuration register sits at four times its printed index

package vbfc_pkg;

    // Register map (byte addresses)
    localparam logic [7:0] CFG_INDEX = 8'h56;
    localparam logic [11:0] ADDR_CFG = {2'b00, CFG_INDEX, 2'b00};
    localparam logic [11:0] ADDR_CTL = 12'h160;
    localparam logic [11:0] ADDR_LINE = 12'h164;
    localparam logic [11:0] ADDR_DELAY = 12'h168;
    localparam logic [11:0] ADDR_STS = 12'h16c;

    // Configuration register field positions
    localparam int CFG_SBS_BIT = 7;
    localparam int CFG_MERGE_BIT = 6;
    localparam int CFG_MODE_LSB = 0;

    // Control register field positions
    localparam int CTL_DUAL_EN_BIT = 0;
    localparam int CTL_CONT_CLK_BIT = 1;
    localparam int CTL_INDEP_BIT = 2;
    localparam int CTL_PORT_SEL_BIT = 3;
    localparam int CTL_SPLIT_BIT = 4;

    // Reset values
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [4:0] CTL_RESET = 5'h00;
    localparam logic [11:0] LINE_RESET = 12'h000;
    localparam logic [7:0] DELAY_RESET = 8'h00;

    // Free FIFO slots needed before input ready is raised
    localparam int FIFO_HEADROOM = 3;

    typedef enum logic [1:0] {
        SRC_DSI,
        SRC_REF_FIRST,
        SRC_REF_SECOND,
        SRC_INTERNAL
    } vbfc_clk_src_t;

    typedef struct packed {
        logic sol;
        logic eol;
        logic [23:0] rgb;
    } vbfc_pix_t;

    typedef struct packed {
        logic [31:0] writedata;
        logic [3:0] byteenable;
        logic [11:0] address;
        logic read;
        logic write;
    } vbfc_avm_req_t;

endpackage

// >>> rtl/vbfc_fifo.sv
// Purpose: synchronous FIFO with valid/ready on both sides
// Assumes: one clock, synchronous active-high reset
// Notes: output word is held in a register; level counts stored words, not counting the one in the output register

`timescale 1ns/1ps

module vbfc_fifo #(
    parameter int WIDTH = 26,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Fill side
    input wire logic s_valid,
    output logic s_ready,
    input wire logic [WIDTH-1:0] s_data,
    // Drain side
    output logic m_valid,
    input wire logic m_ready,
    output logic [WIDTH-1:0] m_data,
    // Status
    output logic [$clog2(DEPTH+1)-1:0] level
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic [$clog2(DEPTH+1)-1:0] count_r;
    logic m_valid_r;
    logic [WIDTH-1:0] m_data_r;
    logic push;
    logic pop;

    assign s_ready = (count_r != DEPTH[$clog2(DEPTH+1)-1:0]);
    assign push = s_valid && s_ready;
    // Refill the output register whenever it is empty or being taken
    assign pop = (count_r != '0) && (!m_valid_r || m_ready);
    assign m_valid = m_valid_r;
    assign m_data = m_data_r;
    assign level = count_r;

    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[wr_ptr_r] <= s_data;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
            end
            if (push && !pop) begin
                count_r <= count_r + 1'b1;
            end else if (pop && !push) begin
                count_r <= count_r - 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            m_valid_r <= 1'b0;
            m_data_r <= '0;
        end else if (pop) begin
            m_valid_r <= 1'b1;
            m_data_r <= mem[rd_ptr_r];
        end else if (m_ready) begin
            m_valid_r <= 1'b0;
        end
    end

endmodule

// >>> rtl/vbfc_top.sv
// Purpose: format conversion and transmitter clock selection for a display bridge
// Assumes: pixel inputs come from receiver logic on ref_clk; no synchronisers needed
// Notes: registers reached over Avalon-MM; output stream buffered in a FIFO
//
// Behaviour
// - With the side-by-side bit set and merge not active, a left/right line is re-emitted as alternating pixels.
// - With the merge bit and the dual-input enable both set, lines from both input ports form one side-by-side line.
// - In merge mode port 0 supplies the left half and port 1 the right half.
// - Clock mode 00 runs the transmitter from the incoming serial-interface clock.
// - Clock mode 01 clocks the transmitter from the first external reference input.
// - Clock mode 10 clocks the transmitter from the internal pixel clock.
// - Clock mode 11 feeds port 0 from the first reference and port 1 from the second.
// - In modes 01 and 10 a continuous or gated input clock is both accepted.
// - In independent 2:2 mode the clock field acts only on the selected port.

`timescale 1ns/1ps

module vbfc_top
    import vbfc_pkg::*;
#(
    parameter int LINE_BUF_DEPTH = 1024,
    parameter int FIFO_DEPTH = 16
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Avalon-MM register slave
    input wire logic [11:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Input port 0
    input wire logic pix0_valid,
    input wire vbfc_pkg::vbfc_pix_t pix0_data,
    output logic pix0_ready,
    // Input port 1
    input wire logic pix1_valid,
    input wire vbfc_pkg::vbfc_pix_t pix1_data,
    output logic pix1_ready,
    // Output stream to the transmitter
    output logic out_valid,
    output vbfc_pkg::vbfc_pix_t out_data,
    input wire logic out_ready,
    // Transmitter clock steering
    output vbfc_pkg::vbfc_clk_src_t tx0_clk_src,
    output vbfc_pkg::vbfc_clk_src_t tx1_clk_src,
    output logic dsi_cont_clk_req,
    output logic int_pclk_en
);
    import vbfc_pkg::*;

    localparam int BW = $clog2(LINE_BUF_DEPTH);
    localparam int LW = $clog2(FIFO_DEPTH + 1);

    typedef enum {ST_P0, ST_P1, ST_LEFT, ST_WAIT, ST_RIGHT} vbfc_state_t;

    // Registers
    logic sbs_en_r;
    logic merge_en_r;
    logic [1:0] clk_mode_r [2];
    logic [4:0] ctl_r;
    logic [11:0] line_len_r;
    logic [7:0] delay_r;
    // Bus slave
    vbfc_avm_req_t req;
    logic waitrequest_r;
    logic [31:0] readdata_r;
    logic [31:0] rd_val;
    // Datapath
    vbfc_state_t state_r;
    vbfc_state_t state_nxt;
    logic [11:0] idx_r;
    logic [7:0] wait_cnt_r;
    vbfc_pix_t pend_r;
    logic pend_valid_r;
    logic pix0_ready_r;
    logic pix1_ready_r;
    logic [23:0] line_buf [LINE_BUF_DEPTH];
    logic first_sol_r;
    logic acc0;
    logic acc1;
    logic merge_on;
    logic sbs_on;
    vbfc_state_t home;
    logic push_valid;
    vbfc_pix_t push_data;
    logic fifo_s_ready;
    logic fifo_m_valid;
    vbfc_pix_t fifo_m_data;
    logic [LW-1:0] fifo_level;
    logic space_ok;
    logic last_left;
    logic [11:0] len_m1;
    // Clock steering
    vbfc_clk_src_t tx0_src_r;
    vbfc_clk_src_t tx1_src_r;
    logic cont_req_r;
    logic int_en_r;

    // Source for one transmitter port given a mode field
    function automatic vbfc_clk_src_t mode_to_src(input logic [1:0] mode, input logic port);
        case (mode)
            2'b00: mode_to_src = SRC_DSI;
            2'b01: mode_to_src = SRC_REF_FIRST;
            2'b10: mode_to_src = SRC_INTERNAL;
            default: mode_to_src = port ? SRC_REF_SECOND : SRC_REF_FIRST;
        endcase
    endfunction

    assign req = '{writedata: avs_writedata, byteenable: avs_byteenable,
                   address: avs_address, read: avs_read, write: avs_write};

    // Merge needs both the format bit and the dual-input enable
    assign merge_on = merge_en_r && ctl_r[CTL_DUAL_EN_BIT];
    // Merge wins when both formats are requested
    assign sbs_on = sbs_en_r && !merge_on;
    assign home = sbs_on ? ST_LEFT : ST_P0;
    assign len_m1 = (line_len_r == '0) ? '0 : line_len_r - 12'h001;
    assign acc0 = pix0_valid && pix0_ready_r;
    assign acc1 = pix1_valid && pix1_ready_r;
    assign last_left = acc0 && (idx_r == len_m1);
    assign space_ok = (fifo_level <= LW'(FIFO_DEPTH - FIFO_HEADROOM));

    // Register read mux
    always_comb begin
        rd_val = 32'h0000_0000;
        if (req.address == ADDR_CFG) begin
            // Bits 5:2 stay zero
            rd_val[CFG_SBS_BIT] = sbs_en_r;
            rd_val[CFG_MERGE_BIT] = merge_en_r;
            rd_val[CFG_MODE_LSB +: 2] = ctl_r[CTL_INDEP_BIT] ?
                clk_mode_r[ctl_r[CTL_PORT_SEL_BIT]] : clk_mode_r[0];
        end else if (req.address == ADDR_CTL) begin
            rd_val[4:0] = ctl_r;
        end else if (req.address == ADDR_LINE) begin
            rd_val[11:0] = line_len_r;
        end else if (req.address == ADDR_DELAY) begin
            rd_val[7:0] = delay_r;
        end else if (req.address == ADDR_STS) begin
            rd_val[0] = merge_on;
            rd_val[1] = sbs_on;
            rd_val[2] = (fifo_level == '0);
            rd_val[3] = !fifo_s_ready;
            rd_val[4] = pend_valid_r;
            rd_val[15:8] = 8'(fifo_level);
        end
    end

    // One wait cycle, then the answer stands for the accepting edge
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            waitrequest_r <= 1'b1;
            readdata_r <= 32'h0000_0000;
        end else if ((req.read || req.write) && waitrequest_r) begin
            waitrequest_r <= 1'b0;
            readdata_r <= req.read ? rd_val : 32'h0000_0000;
        end else begin
            waitrequest_r <= 1'b1;
        end
    end

    // Register writes commit on the edge where waitrequest is seen low
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sbs_en_r <= CFG_RESET[CFG_SBS_BIT];
            merge_en_r <= CFG_RESET[CFG_MERGE_BIT];
            clk_mode_r[0] <= CFG_RESET[CFG_MODE_LSB +: 2];
            clk_mode_r[1] <= CFG_RESET[CFG_MODE_LSB +: 2];
            ctl_r <= CTL_RESET;
            line_len_r <= LINE_RESET;
            delay_r <= DELAY_RESET;
        end else if (req.write && !waitrequest_r) begin
            if (req.address == ADDR_CFG && req.byteenable[0]) begin
                sbs_en_r <= req.writedata[CFG_SBS_BIT];
                merge_en_r <= req.writedata[CFG_MERGE_BIT];
                if (ctl_r[CTL_INDEP_BIT]) begin
                    clk_mode_r[ctl_r[CTL_PORT_SEL_BIT]] <=
                        req.writedata[CFG_MODE_LSB +: 2];
                end else begin
                    clk_mode_r[0] <= req.writedata[CFG_MODE_LSB +: 2];
                    clk_mode_r[1] <= req.writedata[CFG_MODE_LSB +: 2];
                end
            end else if (req.address == ADDR_CTL && req.byteenable[0]) begin
                ctl_r <= req.writedata[4:0];
            end else if (req.address == ADDR_LINE) begin
                if (req.byteenable[0]) begin
                    line_len_r[7:0] <= req.writedata[7:0];
                end
                if (req.byteenable[1]) begin
                    line_len_r[11:8] <= req.writedata[11:8];
                end
            end else if (req.address == ADDR_DELAY && req.byteenable[0]) begin
                delay_r <= req.writedata[7:0];
            end
        end
    end

    // Transmitter clock steering
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            tx0_src_r <= SRC_DSI;
            tx1_src_r <= SRC_DSI;
            cont_req_r <= 1'b1;
            int_en_r <= 1'b0;
        end else begin
            tx0_src_r <= mode_to_src(clk_mode_r[0], 1'b0);
            tx1_src_r <= mode_to_src(clk_mode_r[1], 1'b1);
            // Only the input-clock mode demands a free-running clock
            cont_req_r <= (clk_mode_r[0] == 2'b00) || (clk_mode_r[1] == 2'b00);
            int_en_r <= (clk_mode_r[0] == 2'b10) || (clk_mode_r[1] == 2'b10);
        end
    end

    // Line sequencing
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_P0: begin
                if (acc0 && pix0_data.eol) begin
                    state_nxt = merge_on ? ST_P1 : home;
                end else if (!merge_on && sbs_on) begin
                    state_nxt = ST_LEFT;
                end
            end
            ST_P1: begin
                if (acc1 && pix1_data.eol) begin
                    state_nxt = home;
                end
            end
            ST_LEFT: begin
                if (!sbs_on) begin
                    state_nxt = ST_P0;
                end else if (last_left) begin
                    state_nxt = (delay_r == '0) ? ST_RIGHT : ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (wait_cnt_r == delay_r - 8'h01) begin
                    state_nxt = ST_RIGHT;
                end
            end
            ST_RIGHT: begin
                if (acc0 && (pix0_data.eol || idx_r == len_m1)) begin
                    state_nxt = home;
                end
            end
            default: state_nxt = ST_P0;
        endcase
    end

    // FIFO fill: pending right pixel first, then whatever the state passes on
    always_comb begin
        push_valid = 1'b0;
        push_data = pix0_data;
        if (pend_valid_r) begin
            push_valid = 1'b1;
            push_data = pend_r;
        end else if (state_r == ST_P0 && acc0) begin
            push_valid = 1'b1;
            push_data.eol = pix0_data.eol && !merge_on;
        end else if (state_r == ST_P1 && acc1) begin
            push_valid = 1'b1;
            push_data = pix1_data;
            push_data.sol = 1'b0;
        end else if (state_r == ST_RIGHT && acc0) begin
            push_valid = 1'b1;
            push_data.rgb = line_buf[idx_r[BW-1:0]];
            push_data.sol = (idx_r == '0) && first_sol_r;
            push_data.eol = 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (state_r == ST_LEFT && acc0) begin
            line_buf[idx_r[BW-1:0]] <= pix0_data.rgb;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_r <= ST_P0;
            idx_r <= '0;
            wait_cnt_r <= '0;
            first_sol_r <= 1'b0;
            pend_valid_r <= 1'b0;
            pend_r <= '0;
        end else begin
            state_r <= state_nxt;
            if (state_nxt != state_r) begin
                idx_r <= '0;
            end else if ((state_r == ST_LEFT || state_r == ST_RIGHT) && acc0) begin
                idx_r <= idx_r + 12'h001;
            end
            wait_cnt_r <= (state_r == ST_WAIT) ? wait_cnt_r + 8'h01 : '0;
            if (state_r == ST_LEFT && acc0 && idx_r == '0) begin
                first_sol_r <= pix0_data.sol;
            end
            // Right pixel follows its buffered left partner
            if (state_r == ST_RIGHT && acc0) begin
                pend_valid_r <= 1'b1;
                pend_r <= '{sol: 1'b0, eol: pix0_data.eol || idx_r == len_m1,
                            rgb: pix0_data.rgb};
            end else begin
                pend_valid_r <= 1'b0;
            end
        end
    end

    // Ready is registered, so headroom covers the word in flight
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pix0_ready_r <= 1'b0;
            pix1_ready_r <= 1'b0;
        end else begin
            pix0_ready_r <= space_ok && !(state_r == ST_RIGHT && acc0) &&
                (state_nxt == ST_P0 || state_nxt == ST_LEFT || state_nxt == ST_RIGHT);
            pix1_ready_r <= space_ok && (state_nxt == ST_P1);
        end
    end

    vbfc_fifo #(
        .WIDTH($bits(vbfc_pix_t)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .ref_clk(ref_clk),
        .rst(rst),
        .s_valid(push_valid),
        .s_ready(fifo_s_ready),
        .s_data(push_data),
        .m_valid(fifo_m_valid),
        .m_ready(out_ready),
        .m_data(fifo_m_data),
        .level(fifo_level)
    );

    assign avs_waitrequest = waitrequest_r;
    assign avs_readdata = readdata_r;
    assign pix0_ready = pix0_ready_r;
    assign pix1_ready = pix1_ready_r;
    assign out_valid = fifo_m_valid;
    assign out_data = fifo_m_data;
    assign tx0_clk_src = tx0_src_r;
    assign tx1_clk_src = tx1_src_r;
    assign dsi_cont_clk_req = cont_req_r;
    assign int_pclk_en = int_en_r;

endmodule

// >>> verif/vbfc_top_chk.sv
// Purpose: port-level checks of the format/clock block
// Assumes: one ref_clk domain, rst synchronous active high
// Notes: mirrors the 2:2 controls to know which port a mode write reaches
`timescale 1ns/1ps
module vbfc_top_chk (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Register bus
    input wire logic [11:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    // Output stream and clock steering
    input wire logic out_valid,
    input wire vbfc_pkg::vbfc_pix_t out_data,
    input wire logic out_ready,
    input wire vbfc_pkg::vbfc_clk_src_t tx0_clk_src,
    input wire vbfc_pkg::vbfc_clk_src_t tx1_clk_src,
    input wire logic dsi_cont_clk_req,
    input wire logic int_pclk_en
);
    import vbfc_pkg::*;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    logic indep_r;
    logic sel_r;
    logic acc_w;
    logic cfg_w;
    assign acc_w = avs_write && !avs_waitrequest && avs_byteenable[0];
    assign cfg_w = acc_w && avs_address == ADDR_CFG;
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            indep_r <= 1'b0;
            sel_r <= 1'b0;
        end else if (acc_w && avs_address == ADDR_CTL) begin
            indep_r <= avs_writedata[CTL_INDEP_BIT];
            sel_r <= avs_writedata[CTL_PORT_SEL_BIT];
        end
    end
    a_mode_dsi_both: assert property (
        cfg_w && !indep_r && avs_writedata[1:0] == 2'b00 |-> ##[1:2]
        (tx0_clk_src == SRC_DSI && tx1_clk_src == SRC_DSI)) else $error("mode 00 not applied");
    a_mode_ref_both: assert property (
        cfg_w && !indep_r && avs_writedata[1:0] == 2'b01 |-> ##[1:2]
        (tx0_clk_src == SRC_REF_FIRST && tx1_clk_src == SRC_REF_FIRST))
        else $error("mode 01 not applied");
    a_mode_int_both: assert property (
        cfg_w && !indep_r && avs_writedata[1:0] == 2'b10 |-> ##[1:2]
        (tx0_clk_src == SRC_INTERNAL && tx1_clk_src == SRC_INTERNAL))
        else $error("mode 10 not applied");
    a_dual_ref_p1: assert property (
        cfg_w && indep_r && sel_r && avs_writedata[1:0] == 2'b11 |-> ##[1:2]
        tx1_clk_src == SRC_REF_SECOND) else $error("port 1 not on second reference");
    a_other_port_kept: assert property (
        cfg_w && indep_r && sel_r |=> $stable(tx0_clk_src) [*2])
        else $error("unselected port changed");
    a_cont_req_match: assert property (
        dsi_cont_clk_req == (tx0_clk_src == SRC_DSI || tx1_clk_src == SRC_DSI))
        else $error("continuous clock request wrong");
    a_int_pclk_match: assert property (
        int_pclk_en == (tx0_clk_src == SRC_INTERNAL || tx1_clk_src == SRC_INTERNAL))
        else $error("internal pixel clock enable wrong");
    a_rsvd_read_zero: assert property (
        !avs_waitrequest && avs_read && avs_address == ADDR_CFG |-> avs_readdata[5:2] == 4'h0)
        else $error("reserved bits not zero");
    a_out_word_held: assert property (
        out_valid && !out_ready |=> out_valid && $stable(out_data))
        else $error("output word dropped while stalled");
    a_wait_one_cycle: assert property (
        $fell(avs_waitrequest) |=> avs_waitrequest) else $error("answer longer than one cycle");
    c_cfg_write: cover property (cfg_w && avs_writedata[7]);
    c_line_start: cover property (out_valid && out_ready && out_data.sol);
    c_int_clock: cover property ($rose(int_pclk_en));
endmodule
bind vbfc_top vbfc_top_chk i_chk (
    .ref_clk(ref_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .out_valid(out_valid),
    .out_data(out_data), .out_ready(out_ready), .tx0_clk_src(tx0_clk_src),
    .tx1_clk_src(tx1_clk_src), .dsi_cont_clk_req(dsi_cont_clk_req), .int_pclk_en(int_pclk_en)
);

// >>> verif/vbfc_pix_src.sv
// Purpose: host-side pixel source for one input port
// Assumes: called just after a rising edge
// Notes: idle data is the inverse of the last word, never a stale copy
`timescale 1ns/1ps
module vbfc_pix_src (
    // Clock
    input wire logic ref_clk,
    // Stream towards the block
    output logic valid,
    output vbfc_pkg::vbfc_pix_t data,
    input wire logic ready
);
    import vbfc_pkg::*;
    initial begin
        valid = 1'b0;
        data = '0;
    end
    task automatic send_line(input int n, input logic [23:0] base, input int gap);
        vbfc_pix_t p;
        for (int i = 0; i < n; i++) begin
            p.sol = (i == 0);
            p.eol = (i == n - 1);
            p.rgb = base + 24'(i);
            valid <= 1'b1;
            data <= p;
            do @(posedge ref_clk); while (ready !== 1'b1);
            // Gap zero keeps the stream running back to back
            if (gap > 0 || i == n - 1) begin
                valid <= 1'b0;
                data <= ~p;
                repeat (gap) @(posedge ref_clk);
            end
        end
    endtask
endmodule

// >>> verif/vbfc_top_tb.sv
// Purpose: self-checking bench of the format/clock block
// Assumes: 20 MHz ref_clk, rst held 5 cycles
// Notes: output words collected in a queue by a monitor
`timescale 1ns/1ps
module vbfc_top_tb;
    import vbfc_pkg::*;
    logic ref_clk, rst, avs_read, avs_write, avs_waitrequest, out_valid, out_ready;
    logic pix0_valid, pix0_ready, pix1_valid, pix1_ready, dsi_cont_clk_req, int_pclk_en;
    logic hold, stall;
    logic [11:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic [3:0] avs_byteenable;
    vbfc_pix_t pix0_data, pix1_data, out_data;
    vbfc_clk_src_t tx0_clk_src, tx1_clk_src;
    logic [25:0] got_q[$];
    int bad_count, comparisons, cycles;
    vbfc_top #(.LINE_BUF_DEPTH(1024), .FIFO_DEPTH(16)) i_dut (
        .ref_clk(ref_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .pix0_valid(pix0_valid), .pix0_data(pix0_data), .pix0_ready(pix0_ready),
        .pix1_valid(pix1_valid), .pix1_data(pix1_data), .pix1_ready(pix1_ready),
        .out_valid(out_valid), .out_data(out_data), .out_ready(out_ready),
        .tx0_clk_src(tx0_clk_src), .tx1_clk_src(tx1_clk_src),
        .dsi_cont_clk_req(dsi_cont_clk_req), .int_pclk_en(int_pclk_en));
    vbfc_pix_src i_src0 (.ref_clk(ref_clk), .valid(pix0_valid), .data(pix0_data),
        .ready(pix0_ready));
    vbfc_pix_src i_src1 (.ref_clk(ref_clk), .valid(pix1_valid), .data(pix1_data),
        .ready(pix1_ready));
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        if (out_valid === 1'b1 && out_ready === 1'b1) got_q.push_back(out_data);
        out_ready <= !hold && !(stall && cycles[1]);
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            bad_count++;
            end_sim();
        end
    end
    task automatic end_sim();
        if (bad_count == 0 && comparisons > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !wr;
        avs_write <= wr;
        do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic wait_out(input int n);
        for (int k = 0; k < 400 && got_q.size() < n; k++) @(posedge ref_clk);
        check(got_q.size(), n);
    endtask
    function automatic logic [25:0] px(input logic s, input logic e, input logic [23:0] c);
        return {s, e, c};
    endfunction
    task automatic t_regs();
        bus(0, ADDR_CFG, 0);
        check(rd, 32'h0000_0000);
        bus(1, ADDR_CFG, 32'h0000_00fc);
        bus(0, ADDR_CFG, 0);
        check(rd, 32'h0000_00c0);
        bus(0, 12'h3f0, 0);
        check(rd, 32'h0000_0000);
    endtask
    task automatic t_clk();
        vbfc_clk_src_t exp[3] = '{SRC_DSI, SRC_REF_FIRST, SRC_INTERNAL};
        bus(1, ADDR_CTL, 32'h0000_0002);
        for (int m = 0; m < 3; m++) begin
            bus(1, ADDR_CFG, 32'(m));
            bus(0, ADDR_CFG, 0);
            check(rd, 32'(m));
            check(tx0_clk_src, exp[m]);
            check(tx1_clk_src, exp[m]);
            check(dsi_cont_clk_req, m == 0);
            check(int_pclk_en, m == 2);
        end
        bus(1, ADDR_CTL, 32'h0000_0004);
        bus(1, ADDR_CFG, 32'h0000_0003);
        bus(1, ADDR_CTL, 32'h0000_000c);
        bus(1, ADDR_CFG, 32'h0000_0003);
        bus(0, ADDR_CFG, 0);
        check(tx0_clk_src, SRC_REF_FIRST);
        check(tx1_clk_src, SRC_REF_SECOND);
        bus(1, ADDR_CFG, 32'h0000_0002);
        bus(0, ADDR_CFG, 0);
        check(tx0_clk_src, SRC_REF_FIRST);
        check(tx1_clk_src, SRC_INTERNAL);
        bus(1, ADDR_CTL, 0);
        bus(1, ADDR_CFG, 32'h0000_0001);
    endtask
    task automatic t_fifo();
        got_q.delete();
        hold <= 1'b1;
        fork
            i_src0.send_line(16, 24'h100000, 0);
        join_none
        repeat (40) @(posedge ref_clk);
        check(pix0_ready, 1'b0);
        check(got_q.size(), 0);
        bus(0, ADDR_STS, 0);
        check(rd, 32'h0000_0f00);
        hold <= 1'b0;
        stall <= 1'b1;
        wait_out(16);
        for (int i = 0; i < 16; i++)
            check(got_q[i], px(i == 0, i == 15, 24'h100000 + 24'(i)));
        repeat (4) @(posedge ref_clk);
        check(out_valid, 1'b0);
    endtask
    task automatic t_merge();
        got_q.delete();
        bus(1, ADDR_CFG, 32'h0000_0041);
        @(posedge ref_clk);
        i_src0.send_line(2, 24'h200000, 0);
        wait_out(2);
        check(got_q[1], px(0, 1, 24'h200001));
        got_q.delete();
        bus(1, ADDR_CTL, 32'h0000_0001);
        @(posedge ref_clk);
        fork
            i_src0.send_line(3, 24'h300000, 0);
            i_src1.send_line(3, 24'h400000, 1);
        join
        wait_out(6);
        for (int i = 0; i < 3; i++) begin
            check(got_q[i], px(i == 0, 0, 24'h300000 + 24'(i)));
            check(got_q[i + 3], px(0, i == 2, 24'h400000 + 24'(i)));
        end
    endtask
    task automatic t_sbs();
        got_q.delete();
        bus(1, ADDR_CTL, 0);
        bus(1, ADDR_LINE, 32'h0000_0003);
        bus(1, ADDR_DELAY, 32'h0000_0002);
        bus(1, ADDR_CFG, 32'h0000_0081);
        @(posedge ref_clk);
        i_src0.send_line(6, 24'h500000, 0);
        wait_out(6);
        for (int i = 0; i < 3; i++) begin
            check(got_q[2 * i], px(i == 0, 0, 24'h500000 + 24'(i)));
            check(got_q[2 * i + 1], px(0, i == 2, 24'h500003 + 24'(i)));
        end
    endtask
    initial begin
        rst = 1'b1;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = '0;
        avs_writedata = '0;
        avs_byteenable = 4'hf;
        out_ready = 1'b0;
        hold = 1'b0;
        stall = 1'b0;
        cycles = 0;
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        t_regs();
        t_clk();
        t_fifo();
        t_merge();
        t_sbs();
        end_sim();
    end
endmodule
